// >>> testbench/eeprom_link_checker.sv
// Concurrent checks on the serial link and the device status of the write path
module eeprom_link_checker #(
    parameter int WRITE_CYC = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link pins
    input wire logic sck,
    input wire logic cs_n,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic so_oe_n,
    // Device status
    input wire logic commit,
    input wire logic write_abort,
    input wire logic busy,
    input wire logic latch_set
);
    // ==========================================================
    // Helper logic
    // Busy length counter; a write cycle of the wrong length shows here when busy falls
    logic [19:0] busy_len;
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_len <= 20'h00000;
        end else begin
            busy_len <= busy ? busy_len + 20'h00001 : 20'h00000;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ==========================================================
    // Assertions
    a_output_off: assert property (so_oe_n)
        else $error("serial output enabled on a write-only path");
    a_pause_clock_low: assert property ($changed(hold_n) |-> !sck && !$past(sck))
        else $error("pause changed while serial clock high");
    a_pause_no_clock: assert property (!hold_n |-> !sck)
        else $error("serial clock ran during pause");
    a_idle_clock_low: assert property (cs_n |-> !sck)
        else $error("serial clock ran while deselected");
    a_deselect_gap: assert property ($rose(cs_n) |=> cs_n [*8])
        else $error("deselect gap too short");
    a_commit_needs_latch: assert property (commit |-> $past(latch_set))
        else $error("write started with latch clear");
    a_commit_at_deselect: assert property (commit |-> cs_n && $past(cs_n, 2) && busy)
        else $error("write start not tied to deselect");
    a_busy_length: assert property ($fell(busy) |-> busy_len == WRITE_CYC)
        else $error("write cycle length wrong");
    a_latch_clear_end: assert property ($fell(busy) |-> !latch_set)
        else $error("latch still set after write cycle");
    a_busy_no_restart: assert property (busy && $past(busy) |-> !commit)
        else $error("new write started during write cycle");
    a_protect_clears: assert property ($fell(wp_n) |-> ##[1:6] !latch_set)
        else $error("latch not cleared by protect");
    a_protect_blocks: assert property (!wp_n && !$past(wp_n, 3) && !$past(wp_n, 6) |-> !commit)
        else $error("write started while protected");
    a_abort_exclusive: assert property (write_abort |-> !commit)
        else $error("abort and start together");

    // Main scenarios reached
    c_commit: cover property (commit);
    c_abort: cover property (write_abort);
    c_pause: cover property (!hold_n);
    c_cycle_end: cover property ($fell(busy));
endmodule

// >>> testbench/tb_serial_eeprom_write_protocol.sv
// Testbench: master and device face each other, plus a bench-driven device link
module tb_serial_eeprom_write_protocol import eeprom_wr_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Signals
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    cmd_t cmd_op = CMD_NONE;
    logic [7:0] cmd_addr = 8'h00;
    logic [1:0] cmd_len_m1 = 2'h0;
    logic [31:0] cmd_data = 32'h00000000;
    logic protect = 1'b0;
    logic pause = 1'b0;
    logic ce = 1'b1;
    logic cmd_ready;
    logic done;
    logic [1:0] commit_v, abort_v, busy_v, latch_v;
    logic [7:0] c_addr [2];
    logic [31:0] c_data [2];
    logic [3:0] c_mask [2];
    int n_commit [2] = '{0, 0};
    int n_abort [2] = '{0, 0};
    int base_c [2];
    int base_a [2];
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;

    // ==========================================================
    // Design: link 0 joins both ends, link 1 is driven by the bench
    eeprom_link_if links[2]();
    eeprom_wr_master #(.POWER_CYC(20), .WRITE_CYC(40)) u_eeprom_wr_master (
        .clk(clk), .rst(rst), .ce(ce), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_len_m1(cmd_len_m1), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .done(done), .protect(protect), .pause(pause),
        .link(links[0].master));
    for (genvar i = 0; i < 2; i++) begin : g_end
        eeprom_wr_device #(.WRITE_CYC(20)) u_eeprom_wr_device (
            .clk(clk), .rst(rst), .ce(ce), .link(links[i].device),
            .commit(commit_v[i]), .commit_addr(c_addr[i]), .commit_data(c_data[i]),
            .commit_mask(c_mask[i]), .write_abort(abort_v[i]), .busy(busy_v[i]),
            .latch_set(latch_v[i]));
    end
    eeprom_link_checker #(.WRITE_CYC(20)) u_eeprom_link_checker (
        .clk(clk), .rst(rst), .sck(links[0].sck), .cs_n(links[0].cs_n),
        .hold_n(links[0].hold_n), .wp_n(links[0].wp_n), .so_oe_n(links[0].so_oe_n),
        .commit(commit_v[0]), .write_abort(abort_v[0]), .busy(busy_v[0]),
        .latch_set(latch_v[0]));

    // Clock and pulse counters; pulses last one cycle so they are counted at the edge
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (commit_v[i] === 1'b1) n_commit[i]++;
            if (abort_v[i] === 1'b1) n_abort[i]++;
        end
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            final_report();
        end
    end

    // ==========================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Snapshot of pulse counts, then the count of new starts and aborts
    task automatic mark();
        base_c = n_commit;
        base_a = n_abort;
    endtask
    task automatic pulses(input int i, input int commits, input int aborts);
        check(32'(n_commit[i] - base_c[i]), 32'(commits));
        check(32'(n_abort[i] - base_a[i]), 32'(aborts));
    endtask

    // One command through the master port, waiting for its completion
    task automatic send_cmd(input cmd_t op, input logic [7:0] addr, input logic [1:0] len,
                            input logic [31:0] data);
        int k;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 5000) begin
            @(posedge clk);
            #2;
            k++;
        end
        cmd_op = op;
        cmd_addr = addr;
        cmd_len_m1 = len;
        cmd_data = data;
        cmd_valid = 1'b1;
        @(posedge clk);
        #2;
        cmd_valid = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 5000) begin
            @(posedge clk);
            #2;
            k++;
        end
        check(32'(k < 5000), 32'h1);
    endtask

    // Bench-made frame on link 1, 32 ns clock only inside the frame, optional pause
    task automatic frame_b(input logic [63:0] bits, input int n, input int hold_at);
        links[1].cs_n = 1'b0;
        #500;
        for (int k = 0; k < n; k++) begin
            if (k == hold_at) begin
                links[1].hold_n = 1'b0;
                #200;
                repeat (3) begin
                    links[1].si = ~links[1].si;
                    #16 links[1].sck = 1'b1;
                    #16 links[1].sck = 1'b0;
                end
                links[1].hold_n = 1'b1;
                #200;
            end
            links[1].si = bits[63-k];
            #16 links[1].sck = 1'b1;
            #16 links[1].sck = 1'b0;
        end
        #500 links[1].cs_n = 1'b1;
        links[1].si = ~links[1].si;
        #2000;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        links[1].cs_n = 1'b1;
        links[1].sck = 1'b0;
        links[1].si = 1'b0;
        links[1].hold_n = 1'b1;
        links[1].wp_n = 1'b1;
        repeat (6) @(posedge clk);
        #2 rst = 1'b0;
        @(posedge clk);
        #2;
        check(32'(latch_v), 32'h0);
        check(32'(links[0].so_oe_n), 32'h1);
        check(32'(links[1].so_oe_n), 32'h1);
        check(32'(busy_v), 32'h0);
        check(32'(cmd_ready), 32'h0);
        $display("test power-up done");

        mark();
        send_cmd(CMD_WRITE, 8'h20, 2'h0, 32'h12000000);
        pulses(0, 0, 1);
        send_cmd(CMD_SET_LATCH, 8'h00, 2'h0, 32'h0);
        check(32'(latch_v[0]), 32'h1);
        send_cmd(CMD_CLR_LATCH, 8'h00, 2'h0, 32'h0);
        check(32'(latch_v[0]), 32'h0);
        // The spare command code must not open a frame
        cmd_op = CMD_NONE;
        cmd_valid = 1'b1;
        @(posedge clk);
        #2 cmd_valid = 1'b0;
        check(32'(cmd_ready), 32'h1);
        check(32'(links[0].cs_n), 32'h1);
        $display("test latch commands done");

        send_cmd(CMD_SET_LATCH, 8'h00, 2'h0, 32'h0);
        mark();
        send_cmd(CMD_WRITE, 8'h45, 2'h1, 32'habcd0000);
        pulses(0, 1, 0);
        check(32'(c_addr[0]), 32'h44);
        check(32'(c_mask[0]), 32'h6);
        check(c_data[0] & 32'h00ffff00, 32'h00cdab00);
        check(32'(latch_v[0]), 32'h0);
        $display("test two-byte write done");

        send_cmd(CMD_SET_LATCH, 8'h00, 2'h0, 32'h0);
        mark();
        send_cmd(CMD_WRITE, 8'h4e, 2'h3, 32'h11223344);
        pulses(0, 1, 0);
        check(32'(c_addr[0]), 32'h4c);
        check(32'(c_mask[0]), 32'hf);
        check(c_data[0], 32'h22114433);
        $display("test page wrap done");

        send_cmd(CMD_SET_LATCH, 8'h00, 2'h0, 32'h0);
        // Clock enable low freezes the protect path, so the latch must hold
        ce = 1'b0;
        protect = 1'b1;
        repeat (10) @(posedge clk);
        #2;
        check(32'(latch_v[0]), 32'h1);
        ce = 1'b1;
        repeat (10) @(posedge clk);
        #2;
        check(32'(latch_v[0]), 32'h0);
        mark();
        send_cmd(CMD_WRITE, 8'h30, 2'h0, 32'h77000000);
        pulses(0, 0, 1);
        protect = 1'b0;
        $display("test protect done");

        // Pause lands in mid-frame; the write must still come out whole
        send_cmd(CMD_SET_LATCH, 8'h00, 2'h0, 32'h0);
        mark();
        fork
            send_cmd(CMD_WRITE, 8'h07, 2'h0, 32'h5a000000);
            begin
                repeat (300) @(posedge clk);
                #2 pause = 1'b1;
                repeat (200) @(posedge clk);
                #2 pause = 1'b0;
            end
        join
        pulses(0, 1, 0);
        check(32'(c_addr[0]), 32'h04);
        check(c_data[0] & 32'hff000000, 32'h5a000000);
        $display("test pause done");

        frame_b({OP_SET_LATCH, 56'h0}, 8, -1);
        check(32'(latch_v[1]), 32'h1);
        // Latch already set, so only the missing deselect can stop this write
        mark();
        frame_b({OP_SET_LATCH, OP_WRITE, 8'h10, 8'h77, 32'h0}, 32, -1);
        pulses(1, 0, 0);
        check(32'(latch_v[1]), 32'h1);
        mark();
        frame_b({OP_WRITE, 8'h13, 8'h99, 40'h0}, 25, -1);
        pulses(1, 0, 1);
        mark();
        frame_b({OP_WRITE, 8'h13, 24'hc1c2c3, 24'h0}, 40, 20);
        pulses(1, 1, 0);
        check(32'(c_addr[1]), 32'h10);
        check(32'(c_mask[1]), 32'hb);
        check(c_data[1] & 32'hff00ffff, 32'hc100c3c2);
        check(32'(latch_v[1]), 32'h0);
        $display("test bench-driven link done");
        final_report();
    end
endmodule

// >>> verilog/eeprom_link_if.sv
// Serial link pins between the bus master and the EEPROM write path
interface eeprom_link_if;
    // Master driven pins
    logic sck;
    logic cs_n;
    logic si;
    logic hold_n;
    logic wp_n;
    // Device serial output and its enable, low while driven
    logic so;
    logic so_oe_n;

    modport device(input sck, input cs_n, input si, input hold_n, input wp_n,
                   output so, output so_oe_n);
    modport master(output sck, output cs_n, output si, output hold_n, output wp_n);
endinterface

// >>> verilog/eeprom_wr_device.sv
// EEPROM write path: serial front end on the link clock, write control on clk
module eeprom_wr_device
    import eeprom_wr_pkg::*;
#(
    parameter int WRITE_CYC = WRITE_CYCLES
) (
    // System clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Serial link
    eeprom_link_if.device link,
    // Nonvolatile array side
    output logic commit,
    output logic [ADDR_W-1:0] commit_addr,
    output logic [PAGE_BYTES*BYTE_W-1:0] commit_data,
    output logic [PAGE_BYTES-1:0] commit_mask,
    output logic write_abort,
    output logic busy,
    output logic latch_set
);

    // ==========================================================
    // Link domain state
    logic fresh;
    logic [7:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] opcode;
    logic [ADDR_W-1:0] addr;
    logic [PTR_W-1:0] ptr;
    logic [BYTE_W-1:0] page [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] page_mask;
    logic [7:0] next_cnt;
    logic [7:0] next_shift;
    logic byte_end;

    // ==========================================================
    // System domain state
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic wp_meta;
    logic wp_sync;
    logic armed;
    logic frame_ok;
    logic rise;
    logic cnt_write_ok;
    logic start;
    logic cycle_end;
    logic [TMR_W-1:0] wtmr;

    // Next count and shift value at each accepted link clock
    always_comb begin
        if (fresh) begin
            next_cnt = CNT_ONE;
        end else if (bit_cnt == CNT_MAX) begin
            next_cnt = CNT_MAX;  // Saturate so long frames never alias a valid count
        end else begin
            next_cnt = bit_cnt + CNT_ONE;
        end
        next_shift = {shift[6:0], link.si};
        byte_end = !fresh && (next_cnt >= CNT_FIRST) && (next_cnt[2:0] == BYTE_PHASE_ZERO);
    end

    // Frame start marker: forced while deselected, cleared by the first clock
    // frame restart
    always_ff @(posedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            fresh <= 1'b1;
        end else if (link.hold_n) begin
            fresh <= 1'b0;
        end
    end

    // Bit counter and shift register; counter is kept after deselect for the
    // write decision and only restarts on the next frame's first clock
    // pause freezes state
    always_ff @(posedge link.sck) begin
        if (link.hold_n) begin
            bit_cnt <= next_cnt;
            shift <= next_shift;
        end
    end

    // Opcode and address capture, page pointer advance
    // opcode address data
    always_ff @(posedge link.sck) begin
        if (link.hold_n) begin
            if (next_cnt == CNT_OP) begin
                opcode <= next_shift;
            end
            if (next_cnt == CNT_ADDR) begin
                addr <= next_shift;
                ptr <= next_shift[PTR_W-1:0];
            end else if (byte_end) begin
                ptr <= ptr + 1'b1;
            end
        end
    end

    // Page buffer, one byte lane per entry
    genvar i;
    generate
        for (i = 0; i < PAGE_BYTES; i++) begin : g_lane
            always_ff @(posedge link.sck) begin
                if (link.hold_n) begin
                    if (fresh) begin
                        page_mask[i] <= 1'b0;
                    end else if (byte_end && ptr == PTR_W'(i)) begin
                        page_mask[i] <= 1'b1;
                        page[i] <= next_shift;  // Later bytes overwrite earlier ones
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // Pin synchronisers into the system clock
    always_ff @(posedge clk) begin
        if (rst) begin
            cs_meta <= 1'b0;
            cs_sync <= 1'b0;
            cs_prev <= 1'b0;
            wp_meta <= 1'b0;
            wp_sync <= 1'b0;
        end else if (ce) begin
            cs_meta <= link.cs_n;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
            wp_meta <= link.wp_n;
            wp_sync <= wp_meta;
        end
    end

    // A frame counts only if chip select was seen high before it fell
    // needs falling select
    always_ff @(posedge clk) begin
        if (rst) begin
            armed <= 1'b0;
            frame_ok <= 1'b0;
        end else if (ce) begin
            if (cs_sync) begin
                armed <= 1'b1;
            end
            if (!cs_sync && cs_prev) begin
                frame_ok <= armed;
            end
        end
    end

    // Decisions at deselect. Link registers are read here without further
    // crossing: the link clock is idle while deselected, so they are stable
    // for the whole deselect time the master must honour.
    always_comb begin
        rise = ce && cs_sync && !cs_prev && frame_ok;
        cnt_write_ok = (bit_cnt >= CNT_FIRST) && (bit_cnt <= CNT_LAST)
                       && (bit_cnt[2:0] == BYTE_PHASE_ZERO);
        start = rise && !busy && (opcode == OP_WRITE) && cnt_write_ok
                && latch_set && wp_sync;
        cycle_end = ce && busy && (wtmr == '0);
    end

    // Write enable latch; protect and completion win over a set
    // latch clear events
    always_ff @(posedge clk) begin
        if (rst) begin
            latch_set <= 1'b0;  // latch clear at power-up
        end else if (ce) begin
            if (!wp_sync || cycle_end) begin
                latch_set <= 1'b0;
            end else if (rise && !busy && bit_cnt == CNT_OP) begin
                if (opcode == OP_SET_LATCH) begin
                    latch_set <= 1'b1;
                end else if (opcode == OP_CLR_LATCH) begin
                    latch_set <= 1'b0;
                end
            end
        end
    end

    // Self-timed write cycle; protect no longer matters once it runs
    // timed write cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            busy <= 1'b0;
            wtmr <= '0;
        end else if (ce) begin
            if (start) begin
                busy <= 1'b1;
                wtmr <= TMR_W'(WRITE_CYC - 1);
            end else if (busy) begin
                if (wtmr == '0) begin
                    busy <= 1'b0;
                end else begin
                    wtmr <= wtmr - 1'b1;
                end
            end
        end
    end

    // Array commit pulse and the page it carries
    // page base address
    always_ff @(posedge clk) begin
        if (rst) begin
            commit <= 1'b0;
            write_abort <= 1'b0;
            commit_addr <= '0;
            commit_data <= '0;
            commit_mask <= '0;
        end else if (ce) begin
            commit <= start;
            write_abort <= rise && !start && (opcode == OP_WRITE) && (bit_cnt >= CNT_OP);
            if (start) begin
                commit_addr <= {addr[ADDR_W-1:PTR_W], {PTR_W{1'b0}}};
                commit_data <= {page[3], page[2], page[1], page[0]};
                commit_mask <= page_mask;
            end
        end
    end

    // Read path is absent, so the serial output never leaves high impedance
    // output stays off
    always_ff @(posedge clk) begin
        if (rst) begin
            link.so <= 1'b0;
            link.so_oe_n <= 1'b1;
        end else if (ce) begin
            link.so <= 1'b0;
            link.so_oe_n <= 1'b1;
        end
    end

endmodule

// >>> verilog/eeprom_wr_master.sv
// Bus master end: frames commands onto the serial link from a command port
module eeprom_wr_master
    import eeprom_wr_pkg::*;
#(
    parameter int POWER_CYC = POWER_CYCLES,
    parameter int WRITE_CYC = WRITE_CYCLES
) (
    // System clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Command port
    input wire logic cmd_valid,
    input wire cmd_t cmd_op,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [PTR_W-1:0] cmd_len_m1,
    input wire logic [PAGE_BYTES*BYTE_W-1:0] cmd_data,
    output logic cmd_ready,
    output logic done,
    // Side controls
    input wire logic protect,
    input wire logic pause,
    // Serial link
    eeprom_link_if.master link
);

    // ==========================================================
    // State
    mstate_t state;
    logic [TMR_W-1:0] tmr;
    logic [FRAME_W-1:0] frame;
    logic [7:0] left;
    logic is_write;
    logic tmr_zero;

    assign tmr_zero = (tmr == '0);

    // Write protect pin follows the user level
    always_ff @(posedge clk) begin
        if (rst) begin
            link.wp_n <= 1'b1;
        end else if (ce) begin
            link.wp_n <= !protect;
        end
    end

    // Frame sequencer; sck is divided down from clk here
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= M_POWER;
            tmr <= TMR_W'(POWER_CYC - 1);
            frame <= '0;
            left <= '0;
            is_write <= 1'b0;
            cmd_ready <= 1'b0;
            done <= 1'b0;
            link.sck <= 1'b0;
            link.cs_n <= 1'b1;
            link.si <= 1'b0;
            link.hold_n <= 1'b1;
        end else if (ce) begin
            done <= 1'b0;
            if (!tmr_zero) begin
                tmr <= tmr - 1'b1;
            end
            unique case (state)
                M_POWER: begin
                    if (tmr_zero) begin
                        cmd_ready <= 1'b1;
                        state <= M_IDLE;
                    end
                end
                M_IDLE: begin
                    if (cmd_valid && cmd_op != CMD_NONE) begin
                        cmd_ready <= 1'b0;
                        link.cs_n <= 1'b0;
                        tmr <= TMR_W'(CS_GAP_CYC - 1);
                        is_write <= (cmd_op == CMD_WRITE);
                        if (cmd_op == CMD_WRITE) begin
                            frame <= {OP_WRITE, cmd_addr, cmd_data,
                                      {(FRAME_W - ADDR_W - BYTE_W - PAGE_BYTES*BYTE_W){1'b0}}};
                            left <= CNT_FIRST + {3'h0, cmd_len_m1, 3'h0} - CNT_ONE;
                        end else begin
                            frame <= {(cmd_op == CMD_SET_LATCH) ? OP_SET_LATCH : OP_CLR_LATCH,
                                      {(FRAME_W - BYTE_W){1'b0}}};
                            left <= CNT_OP - CNT_ONE;
                        end
                        state <= M_LEAD;
                    end
                end
                M_LEAD: begin
                    if (tmr_zero) begin
                        link.si <= frame[FRAME_W-1];
                        frame <= {frame[FRAME_W-2:0], 1'b0};
                        tmr <= TMR_W'(SCK_HALF_CYC - 1);
                        state <= M_LOW;
                    end
                end
                M_LOW: begin
                    if (tmr_zero) begin
                        if (pause && link.hold_n) begin
                            link.hold_n <= 1'b0;
                        end else if (!pause && !link.hold_n) begin
                            link.hold_n <= 1'b1;
                            tmr <= TMR_W'(HOLD_SETUP_CYC - 1);
                        end else if (link.hold_n) begin
                            link.sck <= 1'b1;
                            tmr <= TMR_W'(SCK_HALF_CYC - 1);
                            state <= M_HIGH;
                        end
                    end
                end
                M_HIGH: begin
                    if (tmr_zero) begin
                        link.sck <= 1'b0;
                        tmr <= TMR_W'(SCK_HALF_CYC - 1);
                        if (left == '0) begin
                            tmr <= TMR_W'(CS_GAP_CYC - 1);
                            state <= M_LAG;
                        end else begin
                            link.si <= frame[FRAME_W-1];
                            frame <= {frame[FRAME_W-2:0], 1'b0};
                            left <= left - CNT_ONE;
                            state <= M_LOW;
                        end
                    end
                end
                M_LAG: begin
                    if (tmr_zero) begin
                        link.cs_n <= 1'b1;
                        tmr <= TMR_W'(CS_GAP_CYC - 1);
                        state <= M_GAP;
                    end
                end
                M_GAP: begin
                    if (tmr_zero) begin
                        if (is_write) begin
                            tmr <= TMR_W'(WRITE_CYC - 1);
                            state <= M_BUSY;
                        end else begin
                            done <= 1'b1;
                            cmd_ready <= 1'b1;
                            state <= M_IDLE;
                        end
                    end
                end
                M_BUSY: begin
                    // Wait out the device's write cycle; no status read exists
                    if (tmr_zero) begin
                        done <= 1'b1;
                        cmd_ready <= 1'b1;
                        state <= M_IDLE;
                    end
                end
            endcase
        end
    end

endmodule

// >>> verilog/eeprom_wr_pkg.sv
// Shared constants and types for the serial EEPROM write path
package eeprom_wr_pkg;

    // ==========================================================
    // Clock and timing
    localparam int CLK_NS = 40;
    localparam int WRITE_CYCLE_NS = 10000000;
    // Longest time: round down
    localparam int WRITE_CYCLES = WRITE_CYCLE_NS / CLK_NS;
    localparam int POWER_WRITE_NS = 5000000;
    // Least times: round up
    localparam int POWER_CYCLES = (POWER_WRITE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SCK_HALF_NS = 500;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int CS_GAP_NS = 500;
    localparam int CS_GAP_CYC = (CS_GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_SETUP_NS = 200;
    localparam int HOLD_SETUP_CYC = (HOLD_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int TMR_W = 18;

    // ==========================================================
    // Opcodes, sent MSB first
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;

    // ==========================================================
    // Frame layout
    localparam int ADDR_W = 8;
    localparam int BYTE_W = 8;
    localparam int PAGE_BYTES = 4;
    localparam int PTR_W = 2;
    localparam int FRAME_W = 56;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [7:0] CNT_OP = 8'h08;
    localparam logic [7:0] CNT_ADDR = 8'h10;
    localparam logic [7:0] CNT_FIRST = 8'h18;
    localparam logic [7:0] CNT_LAST = 8'h30;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [2:0] BYTE_PHASE_ZERO = 3'h0;

    // ==========================================================
    // Master commands and states
    typedef enum logic [1:0] {
        CMD_SET_LATCH = 2'b00,
        CMD_CLR_LATCH = 2'b01,
        CMD_WRITE = 2'b10,
        CMD_NONE = 2'b11
    } cmd_t;

    typedef enum logic [2:0] {
        M_POWER = 3'b000,
        M_IDLE = 3'b001,
        M_LEAD = 3'b010,
        M_LOW = 3'b011,
        M_HIGH = 3'b100,
        M_LAG = 3'b101,
        M_GAP = 3'b110,
        M_BUSY = 3'b111
    } mstate_t;

endpackage
